// *** verilog/twbm_two_wire_master.sv ***
// Function
// - First bus byte comes from top field
// - Write sends second field as second byte
// - Third field sent; read result overwrites it
// - Bit 7 selects bit-bang or engine
// - Bit 6 selects slow or fast rate
// - Bit 5 suppresses stop, holds clock low
// - Bit 4 suppresses start, single byte
// - Start transactions latch direction from bit 24
// - Bit 3 lets slave stretch clock
// - Count clear writes two bytes
// - Count set writes three bytes
// - Single-byte read answers NACK or ACK
// - Count ignored for start-less writes
// - Clock override releases or forces low
// - Data override releases or forces low
// - Clock bit reads buffered clock pin
// - Data bit reads buffered data pin
// - Done flag set when engine finishes
// - Ack flag follows completion acknowledge
`default_nettype none
module twbm_two_wire_master
   import twbm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_link_clk,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata,
   output logic o_rd_valid,
   input wire logic i_done_clear,
   output logic o_transfer_done,
   output logic o_ack_received,
   output logic o_busy,
   input wire logic i_scl,
   output logic o_scl,
   output logic o_scl_oe,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe
);
   logic [31:0] data_ctrl;
   logic hit;
   logic accept;
   logic launch;
   logic req_tgl;
   logic done_s;
   logic done_d;
   logic done_evt;
   logic [1:0] pins_c;
   logic req_s;
   logic req_d;
   logic req_evt;
   logic eng_sel_l;
   logic scl_ovr_l;
   logic sda_ovr_l;
   logic scl_l;
   logic sda_l;
   twbm_state_t state;
   logic [1:0] q;
   logic [3:0] bitn;
   logic [7:0] shreg;
   logic [1:0] byte_idx;
   logic [1:0] nbytes;
   logic [1:0] last_idx;
   logic is_read;
   logic rx_byte;
   logic ack_ok;
   logic eng_scl_oe;
   logic eng_sda_oe;
   logic dir_latched;
   logic [7:0] res_rx;
   logic res_ack;
   logic res_read;
   logic done_tgl;
   logic tick;
   logic [7:0] cmd_b0;
   logic cmd_nostop;
   logic cmd_nostart;
   logic cmd_cnt;
   twbm_state_t end_state;

   twbm_tick_if tick_if ();

   // Register side, system clock
   assign hit = (i_addr == DATA_CTRL_OFFSET);
   assign accept = i_wr && hit && !o_busy;
   assign launch = accept && i_wdata[BIT_ENGINE];
   assign done_evt = done_s ^ done_d;

   twbm_sync #(
      .WIDTH(3)
   ) u_sync_sys (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({done_tgl, i_scl, i_sda}),
      .o_sync({done_s, pins_c})
   );

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         data_ctrl <= DATA_CTRL_RESET;
      else if (accept)
         data_ctrl <= i_wdata;
      else if (done_evt && res_read)
         data_ctrl[THIRD_MSB:THIRD_LSB] <= res_rx;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_busy <= 1'b0;
         req_tgl <= 1'b0;
      end
      else if (launch)
      begin
         o_busy <= 1'b1;
         req_tgl <= !req_tgl;
      end
      else if (done_evt)
         o_busy <= 1'b0;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         done_d <= 1'b0;
      else
         done_d <= done_s;
   end

   // Set beats clear when both land together
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_transfer_done <= 1'b0;
      else if (done_evt)
         o_transfer_done <= 1'b1;
      else if (i_done_clear)
         o_transfer_done <= 1'b0;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_ack_received <= 1'b0;
      else if (done_evt)
         o_ack_received <= res_ack;
   end

   // Override bits read the pins, not the stored value
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rdata <= 32'h0;
         o_rd_valid <= 1'b0;
      end
      else
      begin
         o_rd_valid <= i_rd;
         if (i_rd)
            o_rdata <= hit ? {data_ctrl[31:2], pins_c} : 32'h0;
      end
   end

   // Link side; fields of data_ctrl stay still while busy
   twbm_sync #(
      .WIDTH(6)
   ) u_sync_link (
      .i_clk(i_link_clk),
      .i_rst(i_rst),
      // Overrides cross inverted: a sync in reset reads as released
      .i_async({req_tgl, data_ctrl[BIT_ENGINE], !data_ctrl[BIT_SCL],
                !data_ctrl[BIT_SDA], i_scl, i_sda}),
      .o_sync({req_s, eng_sel_l, scl_ovr_l, sda_ovr_l, scl_l, sda_l})
   );

   assign cmd_b0 = data_ctrl[FIRST_MSB:FIRST_LSB];
   assign cmd_nostop = data_ctrl[BIT_NOSTOP];
   assign cmd_nostart = data_ctrl[BIT_NOSTART];
   assign cmd_cnt = data_ctrl[BIT_COUNT];
   assign req_evt = req_s ^ req_d;
   assign last_idx = 2'(nbytes - 2'h1);
   assign rx_byte = is_read && (byte_idx == last_idx);
   assign end_state = cmd_nostop ? ST_DONE : ST_STOP;
   assign tick = tick_if.tick;
   assign tick_if.fast = data_ctrl[BIT_SPEED];
   assign tick_if.run = (state == ST_START) || (state == ST_BITS) ||
                        (state == ST_STOP);
   // Without stretch enabled a slave holding the clock is ignored
   // Start and stop wait too, so a held clock cannot corrupt them
   assign tick_if.hold = data_ctrl[BIT_STRETCH] && tick_if.run &&
                         (q == 2'h2) && !scl_l;

   twbm_qtimer u_qtimer (
      .i_clk(i_link_clk),
      .i_rst(i_rst),
      .tif(tick_if)
   );

   function automatic logic [7:0] byte_sel(input logic [1:0] idx);
      byte_sel = (idx == 2'h1) ? data_ctrl[SECOND_MSB:SECOND_LSB] :
                 data_ctrl[THIRD_MSB:THIRD_LSB];
   endfunction

   always_ff @(posedge i_link_clk or posedge i_rst)
   begin
      if (i_rst)
         req_d <= 1'b0;
      else
         req_d <= req_s;
   end

   always_ff @(posedge i_link_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= ST_IDLE;
         q <= 2'h0;
         bitn <= 4'h0;
         shreg <= 8'h0;
         byte_idx <= 2'h0;
         nbytes <= 2'h0;
         is_read <= 1'b0;
         ack_ok <= 1'b0;
         eng_scl_oe <= 1'b0;
         eng_sda_oe <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
               if (req_evt)
               begin
                  q <= 2'h0;
                  bitn <= 4'h0;
                  byte_idx <= 2'h0;
                  shreg <= cmd_b0;
                  ack_ok <= 1'b1;
                  if (cmd_nostart)
                  begin
                     is_read <= dir_latched;
                     nbytes <= 2'h1;
                     eng_scl_oe <= 1'b1;
                     state <= ST_BITS;
                  end
                  else
                  begin
                     is_read <= cmd_b0[0];
                     // Reads carry address then one data byte
                     nbytes <= (cmd_b0[0] || !cmd_cnt) ? 2'h2 : 2'h3;
                     state <= ST_START;
                  end
               end
            ST_START:
               if (tick)
               begin
                  q <= 2'(q + 2'h1);
                  unique case (q)
                     2'h0: eng_sda_oe <= 1'b0;
                     2'h1: eng_scl_oe <= 1'b0;
                     2'h2: eng_sda_oe <= 1'b1;
                     2'h3:
                     begin
                        eng_scl_oe <= 1'b1;
                        state <= ST_BITS;
                     end
                  endcase
               end
            ST_BITS:
               if (tick)
               begin
                  q <= 2'(q + 2'h1);
                  unique case (q)
                     2'h0:
                        if (bitn == ACK_SLOT)
                           eng_sda_oe <= rx_byte ? cmd_cnt : 1'b0;
                        else
                           eng_sda_oe <= rx_byte ? 1'b0 : !shreg[7];
                     2'h1: eng_scl_oe <= 1'b0;
                     2'h2: eng_scl_oe <= 1'b0;
                     2'h3:
                     begin
                        eng_scl_oe <= 1'b1;
                        if (bitn != ACK_SLOT)
                        begin
                           shreg <= {shreg[6:0], sda_l};
                           bitn <= 4'(bitn + 4'h1);
                        end
                        else
                        begin
                           bitn <= 4'h0;
                           // A missing acknowledge aborts the rest
                           if (!rx_byte && sda_l)
                           begin
                              ack_ok <= 1'b0;
                              state <= end_state;
                           end
                           else if (byte_idx == last_idx)
                              state <= end_state;
                           else
                           begin
                              byte_idx <= 2'(byte_idx + 2'h1);
                              shreg <= byte_sel(2'(byte_idx + 2'h1));
                           end
                        end
                     end
                  endcase
               end
            ST_STOP:
               if (tick)
               begin
                  q <= 2'(q + 2'h1);
                  unique case (q)
                     2'h0: eng_sda_oe <= 1'b1;
                     2'h1: eng_scl_oe <= 1'b0;
                     2'h2: eng_sda_oe <= 1'b0;
                     2'h3: state <= ST_DONE;
                  endcase
               end
            ST_DONE:
            begin
               eng_sda_oe <= 1'b0;
               eng_scl_oe <= cmd_nostop;
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_link_clk or posedge i_rst)
   begin
      if (i_rst)
         dir_latched <= 1'b0;
      else if ((state == ST_IDLE) && req_evt && !cmd_nostart)
         dir_latched <= cmd_b0[0];
   end

   always_ff @(posedge i_link_clk or posedge i_rst)
   begin
      if (i_rst)
         res_rx <= 8'h0;
      else if ((state == ST_BITS) && tick && (q == 2'h3) &&
               (bitn == ACK_SLOT) && rx_byte)
         res_rx <= shreg;
   end

   // Results settle at the same edge as the toggle, read three system edges later
   always_ff @(posedge i_link_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         res_ack <= 1'b0;
         res_read <= 1'b0;
         done_tgl <= 1'b0;
      end
      else if (state == ST_DONE)
      begin
         res_ack <= ack_ok;
         res_read <= is_read;
         done_tgl <= !done_tgl;
      end
   end

   always_ff @(posedge i_link_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_scl_oe <= 1'b0;
         o_sda_oe <= 1'b0;
         o_scl <= 1'b0;
         o_sda <= 1'b0;
      end
      else
      begin
         o_scl_oe <= eng_sel_l ? eng_scl_oe : scl_ovr_l;
         o_sda_oe <= eng_sel_l ? eng_sda_oe : sda_ovr_l;
         o_scl <= 1'b0;
         o_sda <= 1'b0;
      end
   end

   AST_DONE_SET: assert property (
      @(posedge i_clk) disable iff (i_rst)
      done_evt |=> o_transfer_done)
      else $error("done flag not set");

   AST_ACK_RESULT: assert property (
      @(posedge i_clk) disable iff (i_rst)
      done_evt |=> (o_ack_received == $past(res_ack)))
      else $error("ack flag wrong at done");

   AST_WRITE_IGNORED: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_wr && hit && o_busy && !done_evt) |=> $stable(data_ctrl))
      else $error("write accepted while busy");

   AST_LAUNCH: assert property (
      @(posedge i_clk) disable iff (i_rst)
      launch |=> (o_busy && (req_tgl != $past(req_tgl))))
      else $error("launch did not start");

   AST_READ_DATA: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (done_evt && res_read) |=>
         (data_ctrl[THIRD_MSB:THIRD_LSB] == $past(res_rx)))
      else $error("read byte not stored");

   AST_SCL_READBACK: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_rd && hit) |=> (o_rdata[BIT_SCL] == $past(pins_c[1])))
      else $error("clock bit readback wrong");

   AST_SDA_READBACK: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_rd && hit) |=> (o_rdata[BIT_SDA] == $past(pins_c[0])))
      else $error("data bit readback wrong");

   AST_FIRST_BYTE: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      ((state == ST_IDLE) && req_evt) |=> (shreg == $past(cmd_b0)))
      else $error("first byte not loaded");

   AST_DIR_LATCH: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      ((state == ST_IDLE) && req_evt && !cmd_nostart) |=>
         (dir_latched == $past(cmd_b0[0])))
      else $error("direction not latched");

   AST_WRITE_TWO: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      ((state == ST_IDLE) && req_evt && !cmd_nostart && !cmd_b0[0] &&
       !cmd_cnt) |=> (nbytes == 2'h2) && (state == ST_START))
      else $error("two byte write miscounted");

   AST_WRITE_THREE: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      ((state == ST_IDLE) && req_evt && !cmd_nostart && !cmd_b0[0] &&
       cmd_cnt) |=> (nbytes == 2'h3))
      else $error("three byte write miscounted");

   AST_NO_START: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      ((state == ST_IDLE) && req_evt && cmd_nostart) |=>
         (nbytes == 2'h1) && (state == ST_BITS))
      else $error("start-less transfer wrong");

   AST_MASTER_ACK: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      ((state == ST_BITS) && tick && (q == 2'h0) && (bitn == ACK_SLOT) &&
       rx_byte) |=> (eng_sda_oe == cmd_cnt))
      else $error("master acknowledge wrong");

   AST_NO_STOP: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      ((state == ST_DONE) && cmd_nostop) |=> eng_scl_oe ##1 eng_scl_oe)
      else $error("clock not held low");

   AST_STRETCH: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      ((state == ST_BITS) && (q == 2'h2) && data_ctrl[BIT_STRETCH] &&
       !scl_l) |-> !tick)
      else $error("stretch not honoured");

   AST_OVERRIDE: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      !eng_sel_l |=> (o_scl_oe == $past(scl_ovr_l)) &&
                     (o_sda_oe == $past(sda_ovr_l)))
      else $error("override not on pins");

   AST_ENGINE_PINS: assert property (
      @(posedge i_link_clk) disable iff (i_rst)
      eng_sel_l |=> (o_scl_oe == $past(eng_scl_oe)) &&
                    (o_sda_oe == $past(eng_sda_oe)))
      else $error("engine not on pins");
endmodule
`default_nettype wire

// *** verilog/twbm_pkg.sv ***
`default_nettype none
package twbm_pkg;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] DATA_CTRL_OFFSET = 12'h110;
   localparam logic [31:0] DATA_CTRL_RESET = 32'h0000_0003;
   localparam int FIRST_MSB = 31;
   localparam int FIRST_LSB = 24;
   localparam int SECOND_MSB = 23;
   localparam int SECOND_LSB = 16;
   localparam int THIRD_MSB = 15;
   localparam int THIRD_LSB = 8;
   localparam int BIT_RW = 24;
   localparam int BIT_ENGINE = 7;
   localparam int BIT_SPEED = 6;
   localparam int BIT_NOSTOP = 5;
   localparam int BIT_NOSTART = 4;
   localparam int BIT_STRETCH = 3;
   localparam int BIT_COUNT = 2;
   localparam int BIT_SCL = 1;
   localparam int BIT_SDA = 0;
   localparam int LINK_CLK_NS = 48;
   localparam int STD_BIT_NS = 10080;
   localparam int FAST_BIT_NS = 2520;
   localparam int QTR_W = 6;
   localparam logic [QTR_W-1:0] STD_QTR_LOAD =
      QTR_W'(STD_BIT_NS / (4 * LINK_CLK_NS) - 1);
   localparam logic [QTR_W-1:0] FAST_QTR_LOAD =
      QTR_W'(FAST_BIT_NS / (4 * LINK_CLK_NS) - 1);
   localparam logic [3:0] ACK_SLOT = 4'h8;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_BITS = 3'h3,
      ST_STOP = 3'h2,
      ST_DONE = 3'h6
   } twbm_state_t;
endpackage
`default_nettype wire

// *** verilog/twbm_tick_if.sv ***
`default_nettype none
interface twbm_tick_if;
   logic fast;
   logic run;
   logic hold;
   logic tick;
   modport gen (input fast, input run, input hold, output tick);
   modport user (output fast, output run, output hold, input tick);
endinterface
`default_nettype wire

// *** verilog/twbm_sync.sv ***
`default_nettype none
module twbm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         // Meta stage feeds only the second stage
         always_ff @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
            begin
               meta[g] <= 1'b0;
               o_sync[g] <= 1'b0;
            end
            else
            begin
               meta[g] <= i_async[g];
               o_sync[g] <= meta[g];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** verilog/twbm_qtimer.sv ***
`default_nettype none
module twbm_qtimer
   import twbm_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   twbm_tick_if.gen tif
);
   logic [QTR_W-1:0] count;
   logic [QTR_W-1:0] reload;

   assign reload = tif.fast ? FAST_QTR_LOAD : STD_QTR_LOAD;
   assign tif.tick = tif.run && !tif.hold && (count == '0);

   // Hold freezes the count so a stretched bit keeps its shape
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         count <= '0;
      else if (!tif.run)
         count <= reload;
      else if (!tif.hold)
         count <= (count == '0) ? reload : QTR_W'(count - 1'b1);
   end

   AST_FAST_QUARTER: assert property (
      @(posedge i_clk) disable iff (i_rst)
      tif.tick && tif.fast |=> (!tif.tick) [*8])
      else $error("quarter period too short");
endmodule
`default_nettype wire

// *** tb/twbm_slave_model.sv ***
`default_nettype none
module twbm_slave_model
(
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [7:0] i_rd_byte,
   input wire logic i_nack,
   input wire logic i_stretch,
   output logic o_scl_pull,
   output logic o_sda_pull
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sh;
   logic [7:0] cur;
   logic [7:0] nrd;
   logic [3:0] bitn;
   logic rd;
   logic first;
   logic ackm;
   logic mack;
   logic [7:0] rx_q[$];
   assign cur = i_rd_byte + nrd;
   initial
   begin
      o_scl_pull = 1'b0;
      o_sda_pull = 1'b0;
      bitn = 4'h0;
      rd = 1'b0;
      first = 1'b0;
      ackm = 1'b0;
      mack = 1'b1;
      nrd = 8'h00;
      sh = 8'h00;
   end
   // Start or repeated start restarts framing
   always @(negedge i_sda)
      if (i_scl)
      begin
         bitn = 4'h0;
         first = 1'b1;
         rd = 1'b0;
      end
   // Stop ends the frame; a later start-less byte frames from zero
   always @(posedge i_sda)
      if (i_scl)
      begin
         bitn = 4'h0;
         rd = 1'b0;
      end
   always @(posedge i_scl)
      if (bitn == 4'h8)
      begin
         bitn = 4'h0;
         if (ackm)
         begin
            mack = i_sda;
            // Real slaves stop driving after a NACK
            if (i_sda)
               rd = 1'b0;
         end
      end
      else
      begin
         sh = {sh[6:0], i_sda};
         bitn = bitn + 4'h1;
      end
   always @(negedge i_scl)
      if (bitn == 4'h8)
      begin
         ackm = rd;
         if (rd)
         begin
            o_sda_pull = 1'b0;
            nrd = nrd + 8'h01;
         end
         else
         begin
            rx_q.push_back(sh);
            if (first)
               rd = sh[0];
            first = 1'b0;
            o_sda_pull = !i_nack;
         end
      end
      else
         o_sda_pull = rd && !cur[3'(7 - bitn)];
   // Stretch each low phase well past a fast quarter
   always @(negedge i_scl)
      if (i_stretch)
      begin
         o_scl_pull = 1'b1;
         #3000;
         o_scl_pull = 1'b0;
      end
endmodule
`default_nettype wire

// *** tb/test_two_wire_bus_master.sv ***
`default_nettype none
module test_two_wire_bus_master
   import twbm_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst, i_link_clk, i_wr, i_rd, i_done_clear;
   logic [ADDR_W-1:0] i_addr;
   logic [31:0] i_wdata, o_rdata, d;
   logic o_rd_valid, o_transfer_done, o_ack_received, o_busy;
   logic o_scl, o_scl_oe, o_sda, o_sda_oe, s_scl, s_sda, nack, stretch;
   logic [7:0] rd_byte;
   wire logic scl, sda;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   realtime t_rise = 0;
   realtime per = 0;
   // Pull-ups: lines high unless someone pulls
   assign scl = !(o_scl_oe || s_scl);
   assign sda = !(o_sda_oe || s_sda);
   twbm_two_wire_master DUT (.i_clk(i_clk), .i_rst(i_rst),
      .i_link_clk(i_link_clk), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
      .i_done_clear(i_done_clear), .o_transfer_done(o_transfer_done),
      .o_ack_received(o_ack_received), .o_busy(o_busy), .i_scl(scl),
      .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda(o_sda),
      .o_sda_oe(o_sda_oe));
   twbm_slave_model slv (.i_scl(scl), .i_sda(sda), .i_rd_byte(rd_byte),
      .i_nack(nack), .i_stretch(stretch), .o_scl_pull(s_scl),
      .o_sda_pull(s_sda));
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = !i_clk;
   end
   initial
   begin
      i_link_clk = 1'b0;
      #7;
      forever #24 i_link_clk = !i_link_clk;
   end
   always @(posedge scl)
   begin
      per = $realtime - t_rise;
      t_rise = $realtime;
   end
   // Ceiling well above the sum of all transfers
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [31:0] v);
      @(negedge i_clk);
      i_addr = DATA_CTRL_OFFSET;
      i_wdata = v;
      i_wr = 1'b1;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask
   task automatic rdreg(input logic [ADDR_W-1:0] a, output logic [31:0] v);
      @(negedge i_clk);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_clk);
      i_rd = 1'b0;
      chk(32'(o_rd_valid), 32'h1);
      v = o_rdata;
   endtask
   task automatic launch(input logic [31:0] v);
      int n;
      slv.rx_q.delete();
      @(negedge i_clk);
      i_done_clear = 1'b1;
      @(negedge i_clk);
      i_done_clear = 1'b0;
      wr(v);
      chk(32'(o_busy), 32'h1);
      wr(32'h5555_55c3);
      n = 0;
      while (o_transfer_done !== 1'b1 && n < 40000)
      begin
         @(negedge i_clk);
         n++;
      end
      chk(32'(o_transfer_done), 32'h1);
      repeat (20) @(negedge i_clk);
      rdreg(DATA_CTRL_OFFSET, d);
      chk(32'(d[31:16]), 32'(v[31:16]));
   endtask
   task automatic chk_rx(input int n, input logic [23:0] b);
      chk(32'(slv.rx_q.size()), 32'(n));
      for (int i = 0; i < n; i++)
         chk(32'(slv.rx_q[i]), 32'(b[23 - 8 * i -: 8]));
   endtask
   task automatic t_reset();
      rdreg(DATA_CTRL_OFFSET, d);
      chk(d, DATA_CTRL_RESET);
      rdreg(12'h114, d);
      chk(d, 32'h0);
   endtask
   task automatic t_bitbang();
      wr(32'h0000_0001);
      repeat (30) @(negedge i_clk);
      chk(32'({o_scl_oe, o_sda_oe}), 32'h2);
      chk(32'({o_scl, o_sda}), 32'h0);
      chk(32'(o_busy), 32'h0);
      rdreg(DATA_CTRL_OFFSET, d);
      chk(32'(d[1:0]), 32'h1);
      wr(32'h0000_0002);
      repeat (30) @(negedge i_clk);
      chk(32'({o_scl_oe, o_sda_oe}), 32'h1);
      rdreg(DATA_CTRL_OFFSET, d);
      chk(32'(d[1:0]), 32'h2);
      wr(32'h0000_0003);
      repeat (30) @(negedge i_clk);
   endtask
   task automatic t_writes();
      launch(32'ha012_3483);
      chk_rx(2, 24'ha01200);
      chk(32'(o_ack_received), 32'h1);
      chk(32'(per > 9834 && per < 10134), 32'h1);
      chk(32'({o_scl_oe, o_sda_oe}), 32'h0);
      launch(32'ha012_34c7);
      chk_rx(3, 24'ha01234);
      chk(32'(per > 2346 && per < 2646), 32'h1);
      launch(32'h7700_00d7);
      chk_rx(1, 24'h770000);
      nack = 1'b1;
      launch(32'ha012_34c3);
      chk(32'(o_ack_received), 32'h0);
      chk_rx(1, 24'ha00000);
      nack = 1'b0;
      stretch = 1'b1;
      launch(32'ha012_34cb);
      chk_rx(2, 24'ha01200);
      chk(32'(per > 3000), 32'h1);
      stretch = 1'b0;
   endtask
   task automatic t_reads();
      rd_byte = 8'h5a;
      slv.nrd = 8'h00;
      launch(32'ha100_00e7);
      chk(32'(d[15:8]), 32'h5a);
      chk(32'(slv.mack), 32'h0);
      chk(32'(o_ack_received), 32'h1);
      chk(32'(o_scl_oe), 32'h1);
      launch(32'h0000_00d3);
      chk(32'(d[15:8]), 32'h5b);
      chk(32'(slv.mack), 32'h1);
      chk(32'({o_scl_oe, o_sda_oe}), 32'h0);
   endtask
   initial
   begin
      i_rst = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_done_clear = 1'b0;
      i_addr = '0;
      i_wdata = '0;
      nack = 1'b0;
      stretch = 1'b0;
      rd_byte = 8'h00;
      repeat (20) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (3) @(negedge i_clk);
      t_reset();
      t_bitbang();
      t_writes();
      t_reads();
      end_sim();
   end
endmodule
`default_nettype wire
